// ### rtl/hotplug_scan.sv
// hot-plug expander scanner: reads the port register of every expander
// assumes open-drain pins resolved outside; inputs already synchronised
`include "strap_misc_regs.svh"

module hotplug_scan
   import strap_misc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // request and result
   input wire logic start_i,
   output logic busy_o,
   output logic [`EXP_COUNT*8-1:0] status_o,
   output logic done_o,
   // open-drain bus
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_oe_o,
   output logic sda_oe_o
);

   hp_state_t state_r;
   logic [7:0] qtr_r;
   logic [1:0] phase_r;
   logic [3:0] bit_r;
   logic [7:0] shift_r;
   logic [`EXP_ADDR_W-1:0] dev_r;
   logic tick;

   // quarter-period tick; a stretched clock holds the high phase
   assign tick = (qtr_r == 8'(`I2C_QTR_CYCLES - 1)) && !(phase_r == 2'h2 && !scl_i);
   assign busy_o = (state_r != HP_IDLE);

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i || state_r == HP_IDLE || tick)
         qtr_r <= 8'h00;
      else if (qtr_r != 8'(`I2C_QTR_CYCLES - 1))
         qtr_r <= qtr_r + 8'h01;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state_r <= HP_IDLE;
         phase_r <= 2'h0;
         bit_r <= 4'h0;
         shift_r <= 8'h00;
         dev_r <= '0;
         scl_oe_o <= 1'b0;
         sda_oe_o <= 1'b0;
         status_o <= '0;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= 1'b0;
         unique case (state_r)
            HP_IDLE:
               if (start_i)
               begin
                  state_r <= HP_START;
                  dev_r <= '0;
                  phase_r <= 2'h0;
               end
            default:
               if (tick)
               begin
                  phase_r <= phase_r + 2'h1;
                  unique case (state_r)
                     HP_START:
                        // sda falls while scl high
                        if (phase_r == 2'h1)
                           sda_oe_o <= 1'b1;
                        else if (phase_r == 2'h3)
                        begin
                           scl_oe_o <= 1'b1;
                           state_r <= HP_ADDR;
                           shift_r <= {`I2C_BASE_ADDR | 7'(dev_r), `I2C_READ_BIT};
                           bit_r <= 4'h0;
                        end
                     HP_ADDR, HP_ADDR_ACK, HP_DATA, HP_NACK:
                     begin
                        if (phase_r == 2'h0)
                        begin
                           unique case (state_r)
                              HP_ADDR: sda_oe_o <= !shift_r[7];
                              HP_NACK: sda_oe_o <= 1'b0;
                              default: sda_oe_o <= 1'b0;
                           endcase
                        end
                        if (phase_r == 2'h1)
                           scl_oe_o <= 1'b0;
                        if (phase_r == 2'h2 && state_r == HP_DATA)
                           shift_r <= {shift_r[6:0], sda_i};
                        if (phase_r == 2'h3)
                        begin
                           scl_oe_o <= 1'b1;
                           bit_r <= bit_r + 4'h1;
                           if (state_r == HP_ADDR)
                              shift_r <= {shift_r[6:0], 1'b0};
                           if (state_r == HP_ADDR && bit_r == 4'h7)
                              state_r <= HP_ADDR_ACK;
                           else if (state_r == HP_ADDR_ACK)
                           begin
                              state_r <= HP_DATA;
                              bit_r <= 4'h0;
                           end
                           else if (state_r == HP_DATA && bit_r == 4'h7)
                              state_r <= HP_NACK;
                           else if (state_r == HP_NACK)
                           begin
                              state_r <= HP_STOP;
                              status_o[8*dev_r +: 8] <= shift_r;
                           end
                        end
                     end
                     HP_STOP:
                        // sda rises while scl high
                        if (phase_r == 2'h0)
                           sda_oe_o <= 1'b1;
                        else if (phase_r == 2'h1)
                           scl_oe_o <= 1'b0;
                        else if (phase_r == 2'h2)
                           sda_oe_o <= 1'b0;
                        else
                           state_r <= HP_NEXT;
                     HP_NEXT:
                        if (dev_r == `EXP_ADDR_W'(`EXP_COUNT - 1))
                        begin
                           state_r <= HP_IDLE;
                           done_o <= 1'b1;
                        end
                        else
                        begin
                           dev_r <= dev_r + `EXP_ADDR_W'(1);
                           state_r <= HP_START;
                           phase_r <= 2'h0;
                        end
                     default: state_r <= HP_IDLE;
                  endcase
               end
         endcase
      end
   end

endmodule : hotplug_scan

// ### rtl/strap_gpio_misc_control.sv
// miscellaneous switch control: gpio port, straps, debug out, hot-plug scan
// assumes pins pass through pads; straps settle before reset is released
// Summary of operation
// - each gpio pin is input-only or driven according to its output-enable bit.
// - gpio bits 1:0 pick the lane layout: 00 five/five, 01 six/six default, 10 five/six.
// - in debug mode gpio bits 4:0 give the debug selection code.
// - the five debug pins drive internal debug status in operation.
// - debug pins 2:0 are sampled at start-up as the operation mode, all low is normal.
// - debug pins 4 and 3 also carry upstream-port-select bits 1 and 0.
// - the management strap picks i2c when high and smbus when low, pulled high by default.
// - a low hot-plug interrupt makes the controller read every expander port register.
// - the hot-plug controller drives an open-drain clock and data pair shared by expanders.
// - with the test input low, the tie-high strap high and debug pins 2:0 all low the device runs in normal mode.
// - four upstream-port strap bits choose the upstream port.
`include "strap_misc_regs.svh"

module strap_gpio_misc_control
   import strap_misc_pkg::*;
(
   // clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   // gpio pins and control
   input wire logic [`GPIO_WIDTH-1:0] GPIO_I,
   output logic [`GPIO_WIDTH-1:0] GPIO_O,
   output logic [`GPIO_WIDTH-1:0] GPIO_OE_O,
   input wire logic [`GPIO_WIDTH-1:0] GPIO_OUT_VAL_I,
   input wire logic [`GPIO_WIDTH-1:0] GPIO_OE_WR_VAL_I,
   input wire logic GPIO_OE_WR_I,
   output logic [`GPIO_WIDTH-1:0] GPIO_IN_VAL_O,
   // debug status pins
   input wire logic [`DBG_WIDTH-1:0] DEBUG_STATUS_I,
   input wire logic [`DBG_WIDTH-1:0] DEBUG_STATUS_OUT_I,
   output logic [`DBG_WIDTH-1:0] DEBUG_STATUS_OUT_O,
   output logic [`DBG_WIDTH-1:0] DEBUG_STATUS_OUT_OE_O,
   // other straps
   input wire logic [1:0] UPSTREAM_PORT_STRAP_I,
   input wire logic SMBUS_SELECT_N_I,
   input wire logic TEST_MODE_I,
   input wire logic TIE_HIGH_TEST_STRAP_I,
   // latched configuration
   output logic [1:0] LANE_CFG_O,
   output logic [2:0] OPERATION_MODE_STRAP_O,
   output logic NORMAL_MODE_O,
   output logic DEBUG_MODE_O,
   output logic [`DBG_WIDTH-1:0] DEBUG_SELECT_O,
   output logic [`UPS_WIDTH-1:0] UPSTREAM_PORT_STRAP_O,
   output logic MGMT_I2C_SELECT_O,
   // hot-plug expander bus
   input wire logic HOTPLUG_IRQ_N_I,
   input wire logic HOTPLUG_SERIAL_CLOCK_I,
   output logic HOTPLUG_SERIAL_CLOCK_O,
   output logic HOTPLUG_SERIAL_CLOCK_OE_O,
   input wire logic HOTPLUG_SERIAL_DATA_I,
   output logic HOTPLUG_SERIAL_DATA_O,
   output logic HOTPLUG_SERIAL_DATA_OE_O,
   output logic [`EXP_COUNT*8-1:0] HOTPLUG_STATUS_O,
   output logic HOTPLUG_DONE_O,
   output logic HOTPLUG_BUSY_O
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   localparam int SYNC_W = `GPIO_WIDTH + `DBG_WIDTH + 2 + 3 + 3;

   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;
   logic [`GPIO_WIDTH-1:0] gpio_s;
   logic [`DBG_WIDTH-1:0] dbg_s;
   logic [1:0] ups_hi_s;
   logic smbus_n_s;
   logic test_s;
   logic irq_n_s;
   logic scl_s;
   logic sda_s;
   logic tie_s;

   always_ff @(posedge CLK_SYS_I)
   begin
      sync1_r <= {GPIO_I, DEBUG_STATUS_OUT_I, UPSTREAM_PORT_STRAP_I, SMBUS_SELECT_N_I,
                  TEST_MODE_I, TIE_HIGH_TEST_STRAP_I, HOTPLUG_IRQ_N_I,
                  HOTPLUG_SERIAL_CLOCK_I, HOTPLUG_SERIAL_DATA_I};
      sync2_r <= sync1_r;
   end

   assign {gpio_s, dbg_s, ups_hi_s, smbus_n_s, test_s, tie_s, irq_n_s, scl_s, sda_s} = sync2_r;

   // ------------------------------------------------------------
   // strap capture
   // ------------------------------------------------------------
   // straps sampled during reset, frozen on the first clock after release
   logic rst_seen_r;
   logic latched_r;

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         rst_seen_r <= 1'b1;
      else
         rst_seen_r <= 1'b0;
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         latched_r <= 1'b0;
      else if (rst_seen_r)
         latched_r <= 1'b1;
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         LANE_CFG_O <= `LANECFG_6P6L;
         OPERATION_MODE_STRAP_O <= `OPMODE_NORMAL;
         UPSTREAM_PORT_STRAP_O <= '0;
         MGMT_I2C_SELECT_O <= 1'b1;
      end
      else if (rst_seen_r && !latched_r)
      begin
         LANE_CFG_O <= gpio_s[1:0];
         OPERATION_MODE_STRAP_O <= dbg_s[2:0];
         UPSTREAM_PORT_STRAP_O <= {ups_hi_s, dbg_s[4:3]};
         MGMT_I2C_SELECT_O <= smbus_n_s;
      end
   end

   // test low and all-low mode strap give normal mode; tie-high strap must be high
   assign NORMAL_MODE_O = !test_s && tie_s
                          && (OPERATION_MODE_STRAP_O == `OPMODE_NORMAL);
   assign DEBUG_MODE_O = latched_r && !NORMAL_MODE_O;

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         DEBUG_SELECT_O <= `DBG_RESET;
      else if (DEBUG_MODE_O)
         DEBUG_SELECT_O <= gpio_s[`DBG_WIDTH-1:0];
   end

   // ------------------------------------------------------------
   // gpio port
   // ------------------------------------------------------------
   logic [`GPIO_WIDTH-1:0] oe_r;

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         oe_r <= `OE_RESET;
      else if (GPIO_OE_WR_I)
         oe_r <= GPIO_OE_WR_VAL_I;
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         GPIO_O <= '0;
         GPIO_IN_VAL_O <= '0;
      end
      else
      begin
         GPIO_O <= GPIO_OUT_VAL_I;
         GPIO_IN_VAL_O <= gpio_s;
      end
   end

   // strap bits stay undriven while their levels are still being sampled
   assign GPIO_OE_O = latched_r ? oe_r : '0;

   // ------------------------------------------------------------
   // debug outputs
   // ------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         DEBUG_STATUS_OUT_O <= `DBG_RESET;
      else
         DEBUG_STATUS_OUT_O <= DEBUG_STATUS_I;
   end

   // released until straps are latched so board resistors set the level
   assign DEBUG_STATUS_OUT_OE_O = latched_r ? {`DBG_WIDTH{1'b1}} : '0;

   // ------------------------------------------------------------
   // hot-plug controller
   // ------------------------------------------------------------
   logic scl_oe;
   logic sda_oe;

   hotplug_scan u_scan
   (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RST_N_I),
      .start_i(latched_r && !irq_n_s),
      .busy_o(HOTPLUG_BUSY_O),
      .status_o(HOTPLUG_STATUS_O),
      .done_o(HOTPLUG_DONE_O),
      .scl_i(scl_s),
      .sda_i(sda_s),
      .scl_oe_o(scl_oe),
      .sda_oe_o(sda_oe)
   );

   // open drain: only ever pulls low
   assign HOTPLUG_SERIAL_CLOCK_O = 1'b0;
   assign HOTPLUG_SERIAL_DATA_O = 1'b0;
   assign HOTPLUG_SERIAL_CLOCK_OE_O = scl_oe;
   assign HOTPLUG_SERIAL_DATA_OE_O = sda_oe;

endmodule : strap_gpio_misc_control

// ### rtl/strap_misc_pkg.sv
// types shared by the strap and hot-plug control block
// assumes the constants header sits beside it in rtl/
`include "strap_misc_regs.svh"

package strap_misc_pkg;

   typedef enum logic [1:0]
   {
      LANES_5P5L,
      LANES_6P6L,
      LANES_5P6L,
      LANES_BAD
   } lane_cfg_t;

   typedef enum logic [3:0]
   {
      HP_IDLE,
      HP_START,
      HP_ADDR,
      HP_ADDR_ACK,
      HP_DATA,
      HP_NACK,
      HP_STOP,
      HP_NEXT
   } hp_state_t;

endpackage : strap_misc_pkg

// ### rtl/strap_misc_regs.svh
// constants for the strap, gpio and hot-plug miscellaneous control block
// assumes inclusion by every file that names these constants
`ifndef STRAP_MISC_REGS_SVH
`define STRAP_MISC_REGS_SVH

`define GPIO_WIDTH 8
`define DBG_WIDTH 5
`define UPS_WIDTH 4
`define EXP_COUNT 4
`define EXP_ADDR_W 3
`define OPMODE_NORMAL 3'h0
`define LANECFG_5P5L 2'h0
`define LANECFG_6P6L 2'h1
`define LANECFG_5P6L 2'h2
`define OE_RESET 8'h00
`define DBG_RESET 5'h00
`define SYS_CLK_KHZ 25000
`define I2C_KHZ 100
`define I2C_QTR_CYCLES ((`SYS_CLK_KHZ + 4 * `I2C_KHZ - 1) / (4 * `I2C_KHZ))
`define I2C_BASE_ADDR 7'h20
`define I2C_READ_BIT 1'b1

`endif

// ### sim/hotplug_expander_model.sv
// four i2c port expanders sharing one interrupt line
// assumes the bench resolves the wired lines with pull-ups
module hotplug_expander_model (
   // bus
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_oe_o,
   // port values and interrupt
   input wire logic [31:0] ports_i,
   input wire logic raise_i,
   output logic irq_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------
   // expanders
   // ---------
   logic [7:0] sh;
   logic [3:0] pend;
   logic hit;
   int k;
   initial
   begin
      sda_oe_o = 1'b0;
      pend = 4'h0;
      hit = 1'b0;
      k = -2;
   end
   // line stays low until every changed port is read
   assign irq_n_o = ~|pend;
   always @(posedge raise_i) pend = 4'hf;
   always @(sda_i)
      if (scl_i === 1'b1)
         k = sda_i ? -2 : -1;
   always @(posedge scl_i)
      if (k >= 0 && k < 8)
         sh = {sh[6:0], sda_i};
   always @(negedge scl_i)
      if (k >= -1)
      begin
         k++;
         if (k == 8)
         begin
            hit = sh[7:3] == 5'h08 && sh[0];
            sda_oe_o = hit;
         end
         else if (k > 8 && k < 17)
            sda_oe_o = hit & ~ports_i[sh[2:1] * 8 + 16 - k];
         else
         begin
            sda_oe_o = 1'b0;
            if (k == 17 && hit)
               pend[sh[2:1]] = 1'b0;
         end
      end
endmodule : hotplug_expander_model

// ### sim/strap_gpio_misc_control_monitor.sv
// assertions on the ports of the strap, gpio and hot-plug block
// assumes it is bound to the top module; one clock domain
`include "strap_misc_regs.svh"
module strap_gpio_misc_control_monitor (
   // clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   // gpio and debug
   input wire logic [`GPIO_WIDTH-1:0] GPIO_O,
   input wire logic [`GPIO_WIDTH-1:0] GPIO_OE_O,
   input wire logic [`GPIO_WIDTH-1:0] GPIO_OUT_VAL_I,
   input wire logic [`GPIO_WIDTH-1:0] GPIO_OE_WR_VAL_I,
   input wire logic GPIO_OE_WR_I,
   input wire logic [`DBG_WIDTH-1:0] DEBUG_STATUS_I,
   input wire logic [`DBG_WIDTH-1:0] DEBUG_STATUS_OUT_O,
   input wire logic [`DBG_WIDTH-1:0] DEBUG_STATUS_OUT_OE_O,
   // straps
   input wire logic TEST_MODE_I,
   input wire logic TIE_HIGH_TEST_STRAP_I,
   input wire logic [1:0] LANE_CFG_O,
   input wire logic [2:0] OPERATION_MODE_STRAP_O,
   input wire logic NORMAL_MODE_O,
   input wire logic [`UPS_WIDTH-1:0] UPSTREAM_PORT_STRAP_O,
   input wire logic MGMT_I2C_SELECT_O,
   // hot-plug
   input wire logic HOTPLUG_IRQ_N_I,
   input wire logic HOTPLUG_SERIAL_CLOCK_O,
   input wire logic HOTPLUG_SERIAL_CLOCK_OE_O,
   input wire logic HOTPLUG_SERIAL_DATA_O,
   input wire logic HOTPLUG_SERIAL_DATA_OE_O,
   input wire logic HOTPLUG_DONE_O,
   input wire logic HOTPLUG_BUSY_O
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------
   // checks
   // ------
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!RST_N_I);
   // debug pin drive doubles as the latched flag
   wire lat = DEBUG_STATUS_OUT_OE_O[0];
   chk_oe_write: assert property (lat && GPIO_OE_WR_I |=> GPIO_OE_O == $past(GPIO_OE_WR_VAL_I))
      else $error("oe write lost");
   chk_oe_latch: assert property (!lat |-> GPIO_OE_O == 8'h00)
      else $error("oe before latch");
   chk_gpio_drive: assert property ($past(RST_N_I) |-> GPIO_O == $past(GPIO_OUT_VAL_I))
      else $error("gpio value");
   chk_debug_copy: assert property (lat |=> DEBUG_STATUS_OUT_O == $past(DEBUG_STATUS_I))
      else $error("debug copy");
   chk_debug_on: assert property ($rose(RST_N_I) |-> ##[1:3] DEBUG_STATUS_OUT_OE_O == 5'h1f)
      else $error("debug drive");
   // mode pins reach the decode through the two-flop synchroniser
   chk_normal_mode: assert property (NORMAL_MODE_O == (!$past(TEST_MODE_I, 2)
      && $past(TIE_HIGH_TEST_STRAP_I, 2) && OPERATION_MODE_STRAP_O == 3'h0))
      else $error("normal mode");
   chk_straps_held: assert property (lat && $past(lat) |-> $stable(LANE_CFG_O)
      && $stable(UPSTREAM_PORT_STRAP_O) && $stable(MGMT_I2C_SELECT_O)
      && $stable(OPERATION_MODE_STRAP_O))
      else $error("strap moved");
   chk_scan_start: assert property ($fell(HOTPLUG_IRQ_N_I) && !HOTPLUG_BUSY_O && lat
      |-> ##[1:4] HOTPLUG_BUSY_O)
      else $error("scan not started");
   chk_done_pulse: assert property (HOTPLUG_DONE_O |=> !HOTPLUG_DONE_O)
      else $error("done too long");
   chk_open_drain: assert property (!HOTPLUG_SERIAL_CLOCK_O && !HOTPLUG_SERIAL_DATA_O)
      else $error("line driven high");
   chk_bus_idle: assert property (!HOTPLUG_BUSY_O |-> !HOTPLUG_SERIAL_CLOCK_OE_O)
      else $error("clock held idle");
   chk_data_idle: assert property (!HOTPLUG_BUSY_O |-> !HOTPLUG_SERIAL_DATA_OE_O)
      else $error("data held idle");
endmodule : strap_gpio_misc_control_monitor
bind strap_gpio_misc_control strap_gpio_misc_control_monitor mon (
   .CLK_SYS_I(CLK_SYS_I),
   .RST_N_I(RST_N_I),
   .GPIO_O(GPIO_O),
   .GPIO_OE_O(GPIO_OE_O),
   .GPIO_OUT_VAL_I(GPIO_OUT_VAL_I),
   .GPIO_OE_WR_VAL_I(GPIO_OE_WR_VAL_I),
   .GPIO_OE_WR_I(GPIO_OE_WR_I),
   .DEBUG_STATUS_I(DEBUG_STATUS_I),
   .DEBUG_STATUS_OUT_O(DEBUG_STATUS_OUT_O),
   .DEBUG_STATUS_OUT_OE_O(DEBUG_STATUS_OUT_OE_O),
   .TEST_MODE_I(TEST_MODE_I),
   .TIE_HIGH_TEST_STRAP_I(TIE_HIGH_TEST_STRAP_I),
   .LANE_CFG_O(LANE_CFG_O),
   .OPERATION_MODE_STRAP_O(OPERATION_MODE_STRAP_O),
   .NORMAL_MODE_O(NORMAL_MODE_O),
   .UPSTREAM_PORT_STRAP_O(UPSTREAM_PORT_STRAP_O),
   .MGMT_I2C_SELECT_O(MGMT_I2C_SELECT_O),
   .HOTPLUG_IRQ_N_I(HOTPLUG_IRQ_N_I),
   .HOTPLUG_SERIAL_CLOCK_O(HOTPLUG_SERIAL_CLOCK_O),
   .HOTPLUG_SERIAL_CLOCK_OE_O(HOTPLUG_SERIAL_CLOCK_OE_O),
   .HOTPLUG_SERIAL_DATA_O(HOTPLUG_SERIAL_DATA_O),
   .HOTPLUG_SERIAL_DATA_OE_O(HOTPLUG_SERIAL_DATA_OE_O),
   .HOTPLUG_DONE_O(HOTPLUG_DONE_O),
   .HOTPLUG_BUSY_O(HOTPLUG_BUSY_O)
);

// ### sim/strap_gpio_misc_control_tb_top.sv
// self-checking bench: straps, gpio, debug pins and a hot-plug scan
// assumes the design in rtl/ and the expander model in sim/
`define CHK(nm, ex, gt) \
   begin \
      comparisons++; \
      if ((ex) !== (gt)) \
      begin \
         err_count++; \
         $display("Error %s expected %0h got %0h", nm, ex, gt); \
      end \
   end
module strap_gpio_misc_control_tb_top import strap_misc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // -----
   // bench
   // -----
   int err_count;
   int comparisons;
   logic clk, rst_n, oe_wr, smb_n, test, tie, raise, hp_done, hp_busy, norm, dbgm, i2c_sel;
   logic [7:0] g_in, g_o, g_oe, out_v, oe_v, in_v, q[$];
   logic [4:0] dst, d_o, d_oe, dsel;
   logic [3:0] ups, ups_o;
   logic [2:0] op, opm;
   logic [1:0] lane;
   logic [31:0] ports, hp_st;
   logic scl_oe, sda_oe, scl_o, sda_o, m_oe, irq_n;
   wire scl = ~scl_oe;
   wire sda = ~(sda_oe | m_oe);
   wire [7:0] g_pin = (g_oe & g_o) | (~g_oe & g_in);
   wire [4:0] d_pin = (d_oe & d_o) | (~d_oe & {ups[1:0], op});
   strap_gpio_misc_control dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .GPIO_I(g_pin),
      .GPIO_O(g_o), .GPIO_OE_O(g_oe), .GPIO_OUT_VAL_I(out_v), .GPIO_OE_WR_VAL_I(oe_v),
      .GPIO_OE_WR_I(oe_wr), .GPIO_IN_VAL_O(in_v), .DEBUG_STATUS_I(dst),
      .DEBUG_STATUS_OUT_I(d_pin), .DEBUG_STATUS_OUT_O(d_o), .DEBUG_STATUS_OUT_OE_O(d_oe),
      .UPSTREAM_PORT_STRAP_I(ups[3:2]), .SMBUS_SELECT_N_I(smb_n), .TEST_MODE_I(test),
      .TIE_HIGH_TEST_STRAP_I(tie), .LANE_CFG_O(lane), .OPERATION_MODE_STRAP_O(opm),
      .NORMAL_MODE_O(norm), .DEBUG_MODE_O(dbgm), .DEBUG_SELECT_O(dsel),
      .UPSTREAM_PORT_STRAP_O(ups_o), .MGMT_I2C_SELECT_O(i2c_sel), .HOTPLUG_IRQ_N_I(irq_n),
      .HOTPLUG_SERIAL_CLOCK_I(scl), .HOTPLUG_SERIAL_CLOCK_O(scl_o),
      .HOTPLUG_SERIAL_CLOCK_OE_O(scl_oe), .HOTPLUG_SERIAL_DATA_I(sda),
      .HOTPLUG_SERIAL_DATA_O(sda_o), .HOTPLUG_SERIAL_DATA_OE_O(sda_oe),
      .HOTPLUG_STATUS_O(hp_st), .HOTPLUG_DONE_O(hp_done), .HOTPLUG_BUSY_O(hp_busy));
   hotplug_expander_model exp_m (.scl_i(scl), .sda_i(sda), .sda_oe_o(m_oe), .ports_i(ports),
      .raise_i(raise), .irq_n_o(irq_n));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic print_verdict();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // one scan needs about 20.4k cycles
   initial
   begin
      #(60000 * 40);
      err_count++;
      print_verdict();
   end
   initial
   begin
      logic [1:0] xl;
      logic [3:0] xu;
      logic [2:0] xo;
      logic [7:0] po, pv;
      logic [4:0] pd;
      int n;
      err_count = 0;
      comparisons = 0;
      rst_n = 1'b0;
      tie = 1'b1;
      {oe_wr, smb_n, test, raise, g_in, out_v, oe_v, dst, ups, op, ports} = '0;
      void'($urandom(32'hd8b59775));
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk);
         xl = (i == 3) ? 2'h1 : 2'(i);
         xo = (i == 3) ? 3'($urandom_range(7, 1)) : 3'h0;
         xu = 4'($urandom);
         rst_n <= 1'b0;
         g_in <= {6'($urandom), xl};
         op <= xo;
         ups <= xu;
         smb_n <= i[0];
         test <= (i == 2);
         cyc(7);
         `CHK("lane reset", 2'h1, lane)
         `CHK("i2c reset", 1'b1, i2c_sel)
         `CHK("oe reset", 8'h00, g_oe)
         `CHK("debug oe reset", 5'h00, d_oe)
         @(posedge clk) rst_n <= 1'b1;
         cyc(4);
         `CHK("lane", xl, lane)
         `CHK("opmode", xo, opm)
         `CHK("normal", xo == 0 && i != 2, norm)
         `CHK("debug mode", !(xo == 0 && i != 2), dbgm)
         `CHK("upstream", xu, ups_o)
         `CHK("i2c select", i[0], i2c_sel)
         if (i >= 2) `CHK("select", g_in[4:0], dsel)
         @(posedge clk);
         g_in <= ~g_in;
         ups <= ~ups;
         op <= ~op;
         smb_n <= ~smb_n;
         cyc(5);
         `CHK("lane held", xl, lane)
         `CHK("upstream held", xu, ups_o)
         `CHK("i2c held", i[0], i2c_sel)
         if (i >= 2) `CHK("select follows", g_in[4:0], dsel)
      end
      // back-to-back enable writes, four checks per cycle
      for (int i = 0; i < 9; i++)
      begin
         @(posedge clk);
         po = oe_v;
         pv = out_v;
         pd = dst;
         oe_v <= 8'($urandom);
         out_v <= 8'($urandom);
         dst <= 5'($urandom);
         oe_wr <= (i < 8);
         #1;
         if (i > 0)
         begin
            `CHK("oe", po, g_oe)
            `CHK("gpio out", pv, g_o)
            `CHK("debug out", pd, d_o)
            `CHK("debug oe", 5'h1f, d_oe)
         end
      end
      cyc(5);
      `CHK("gpio in", (po & out_v) | (~po & g_in), in_v)
      repeat (4) q.push_back(8'($urandom));
      @(posedge clk);
      ports <= {q[3], q[2], q[1], q[0]};
      raise <= 1'b1;
      cyc(6);
      `CHK("busy", 1'b1, hp_busy)
      @(posedge clk) raise <= 1'b0;
      #1;
      n = 0;
      while (hp_done !== 1'b1 && n < 40000)
      begin
         cyc(1);
         n++;
      end
      `CHK("scan done", 1'b1, hp_done)
      cyc(2);
      for (int j = 0; j < 4; j++)
         `CHK("expander byte", q[j], hp_st[j*8 +: 8])
      `CHK("irq released", 1'b1, irq_n)
      print_verdict();
   end
endmodule : strap_gpio_misc_control_tb_top
